//--- src/usb_endpoint_buffer_manager.sv
// Module: endpoint 2 double-block buffer manager with events and arbiter
// Function
// - Three endpoints; ep0/ep1 two 16-byte buffers, ep2 two 64-byte, mode-steered.
// - Endpoint 2 store is two 512-byte blocks used alternately.
// - Managed modes answer NAK while the current block is unavailable, except in a block-end stall (invalid).
// - Mode field: 00 normal, 10 download, 01 upload.
// - Normal mode: after each correct transfer, that direction goes to NAK.
// - Managed modes advance the ep2 address 64 bytes per packet to block end.
// - After 512 bytes always switch block; invalid until release if the new block is unavailable.
// - Short received packet returns to normal mode, data kept in a block.
// - Per-block status flags are presented to the coprocessor.
// - Hardware-only current buffer bit 3 names the block holding data.
// - Bits 2:1 per block: upload full/not full, download not empty/empty.
// - Writing 1 to bit 0 clears index, flags and packet counter.
// - In wait the logic runs and enabled events wake the processor.
// - In halt the logic freezes; end-of-suspend activity resumes it.
// - Seven events, each with its own enable; only end of suspend exits halt.
// - End of suspend has its own line; others share one; global masks gate.
// - Shared buffer arbiter, untimed ownership, priority cpu, usb, coprocessor.
`timescale 1ns/1ps
module usb_endpoint_buffer_manager (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [3:0]        adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	// Serial engine side
	input  wire logic              ep2_done_i,
	input  wire logic              ep2_dir_in_i,
	input  wire logic              ep2_short_i,
	input  wire logic [6:0]        usb_event_i,
	input  wire logic              bus_activity_i,
	output usb_buf_pkg::ep_status_e ep2_rx_status_o,
	output usb_buf_pkg::ep_status_e ep2_tx_status_o,
	output logic      [9:0]        ep2_addr_o,
	output logic      [1:0]        transfer_mode_field_o,
	// Coprocessor side
	input  wire logic [1:0]        block_release_i,
	output logic      [1:0]        block_status_flags_o,
	output logic                   current_buffer_index_o,
	// Shared buffer arbiter
	input  wire logic              cpu_req_i,
	input  wire logic              usb_req_i,
	input  wire logic              cop_req_i,
	output usb_buf_pkg::grant_s    grant_o,
	// Processor power and interrupts
	input  wire logic              wait_i,
	input  wire logic              halt_i,
	input  wire logic [1:0]        global_interrupt_masks_i,
	output logic                   usb_irq_o,
	output logic                   end_of_suspend_flag_irq_o,
	output logic                   wake_wait_o,
	output logic                   wake_halt_o
);
	usb_buf_pkg::state_s s_q;
	usb_buf_pkg::state_s s_d;

	logic       managed;
	logic       bus_req;
	logic       wr_stb;
	logic [6:0] pend;
	logic       masks_open;
	usb_buf_pkg::ep_status_e mgd_status;

	// Block usable by the USB side in the present mode
	function automatic logic blk_avail(input logic [1:0] mode,
		input logic flag);
		blk_avail = (mode == usb_buf_pkg::MODE_UPLOAD) ? flag : ~flag;
	endfunction

	assign managed    = (s_q.mode == usb_buf_pkg::MODE_UPLOAD) ||
		(s_q.mode == usb_buf_pkg::MODE_DOWNLOAD);
	assign bus_req    = cyc_i && stb_i;
	// Write lands on the edge where the master sees ack
	assign wr_stb     = bus_req && we_i && s_q.ack && sel_i[0];
	assign pend       = s_q.ev_flags & s_q.ev_en;
	assign masks_open = (global_interrupt_masks_i == 2'h0);

	always_comb begin
		if (s_q.stalled) begin
			mgd_status = usb_buf_pkg::EP_INVALID;
		end else if (blk_avail(s_q.mode, s_q.blk_flags[s_q.cur_blk])) begin
			mgd_status = usb_buf_pkg::EP_VALID;
		end else begin
			mgd_status = usb_buf_pkg::EP_NAK;
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.act_sync = {s_q.act_sync[0], bus_activity_i};
		s_d.ack = bus_req && !s_q.ack;
		if (halt_i) begin
			// Registers frozen; only resume activity is noticed
			s_d.ack = 1'b0;
			if (s_q.act_sync[1]) begin
				s_d.ev_flags[usb_buf_pkg::EV_END_OF_SUSPEND_FLAG] = 1'b1;
			end
		end else begin
			// Read data captured with the ack
			if (bus_req && !s_q.ack) begin
				case (adr_i)
					usb_buf_pkg::BUF_CSR_OFS: begin
						s_d.rdata = {4'h0, s_q.buf_index, s_q.blk_flags,
							1'b0};
					end
					usb_buf_pkg::USB_CTL_OFS: begin
						s_d.rdata = {4'h0, s_q.ep2_valid, s_q.mode};
					end
					usb_buf_pkg::EV_FLAG_OFS: begin
						s_d.rdata = {1'b0, s_q.ev_flags};
					end
					usb_buf_pkg::EV_EN_OFS: begin
						s_d.rdata = {1'b0, s_q.ev_en};
					end
					default: begin
						s_d.rdata = 8'h00;
					end
				endcase
			end
			// Software writes
			if (wr_stb) begin
				case (adr_i)
					usb_buf_pkg::BUF_CSR_OFS: begin
						if (dat_i[usb_buf_pkg::CSR_CLEAR_BIT]) begin
							s_d.buf_index = 1'b0;
							s_d.blk_flags = 2'h0;
							s_d.pkt_cnt   = 3'h0;
							s_d.cur_blk   = 1'b0;
							s_d.stalled   = 1'b0;
						end
					end
					usb_buf_pkg::USB_CTL_OFS: begin
						s_d.mode = dat_i[usb_buf_pkg::CTL_MODE_LSB +: 2];
						s_d.ep2_valid =
							dat_i[usb_buf_pkg::CTL_VALID_LSB +: 2];
					end
					usb_buf_pkg::EV_FLAG_OFS: begin
						s_d.ev_flags = s_q.ev_flags & ~dat_i[6:0];
					end
					usb_buf_pkg::EV_EN_OFS: begin
						s_d.ev_en = dat_i[6:0];
					end
					default: begin
					end
				endcase
			end
			// Hardware event set wins over a same-cycle clear
			s_d.ev_flags = s_d.ev_flags | usb_event_i;
			if (s_q.act_sync[1]) begin
				s_d.ev_flags[usb_buf_pkg::EV_END_OF_SUSPEND_FLAG] = 1'b1;
			end
			// Endpoint 2 packet completion
			if (ep2_done_i) begin
				if (!managed) begin
					s_d.ep2_valid[ep2_dir_in_i] = 1'b0;
					s_d.buf_index = s_q.cur_blk;
				end else if (ep2_short_i && !ep2_dir_in_i) begin
					s_d.mode      = usb_buf_pkg::MODE_NORMAL;
					s_d.buf_index = s_q.cur_blk;
					s_d.pkt_cnt   = 3'h0;
				end else if (s_q.pkt_cnt == usb_buf_pkg::LAST_PKT) begin
					// Block done: mark it for the coprocessor, move on
					s_d.blk_flags[s_q.cur_blk] =
						(s_q.mode == usb_buf_pkg::MODE_DOWNLOAD);
					s_d.cur_blk   = ~s_q.cur_blk;
					s_d.buf_index = ~s_q.cur_blk;
					s_d.pkt_cnt   = 3'h0;
					s_d.stalled   = !blk_avail(s_q.mode,
						s_q.blk_flags[~s_q.cur_blk]);
				end else begin
					s_d.pkt_cnt = s_q.pkt_cnt + 3'h1;
				end
			end
			// Coprocessor release wins over the USB-side update
			for (int b = 0; b < 2; b++) begin
				if (block_release_i[b]) begin
					s_d.blk_flags[b] =
						(s_q.mode == usb_buf_pkg::MODE_UPLOAD);
				end
			end
			if (s_d.stalled &&
				blk_avail(s_d.mode, s_d.blk_flags[s_d.cur_blk])) begin
				s_d.stalled = 1'b0;
			end
			// Arbiter: owner keeps the buffer until it drops its request
			if (!((s_q.grant.cpu && cpu_req_i) ||
				(s_q.grant.usb && usb_req_i) ||
				(s_q.grant.cop && cop_req_i))) begin
				s_d.grant.cpu = cpu_req_i;
				s_d.grant.usb = !cpu_req_i && usb_req_i;
				s_d.grant.cop = !cpu_req_i && !usb_req_i && cop_req_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q           <= '0;
			s_q.rdata     <= usb_buf_pkg::CSR_RESET;
			s_q.ev_flags  <= usb_buf_pkg::EV_RESET_VAL;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign dat_o = {24'h0, s_q.rdata};
	assign ack_o = s_q.ack;
	assign ep2_addr_o = {s_q.cur_blk, s_q.pkt_cnt, 6'h00};
	assign transfer_mode_field_o  = s_q.mode;
	assign block_status_flags_o   = s_q.blk_flags;
	assign current_buffer_index_o = s_q.buf_index;
	assign grant_o = s_q.grant;
	assign ep2_rx_status_o = managed ?
		((s_q.mode == usb_buf_pkg::MODE_DOWNLOAD) ? mgd_status :
		usb_buf_pkg::EP_NAK) :
		(s_q.ep2_valid[0] ? usb_buf_pkg::EP_VALID : usb_buf_pkg::EP_NAK);
	assign ep2_tx_status_o = managed ?
		((s_q.mode == usb_buf_pkg::MODE_UPLOAD) ? mgd_status :
		usb_buf_pkg::EP_NAK) :
		(s_q.ep2_valid[1] ? usb_buf_pkg::EP_VALID : usb_buf_pkg::EP_NAK);
	assign end_of_suspend_flag_irq_o = pend[usb_buf_pkg::EV_END_OF_SUSPEND_FLAG] && masks_open;
	assign usb_irq_o = masks_open && |(pend &
		~(7'h01 << usb_buf_pkg::EV_END_OF_SUSPEND_FLAG));
	assign wake_wait_o = wait_i && (|pend);
	assign wake_halt_o = halt_i && pend[usb_buf_pkg::EV_END_OF_SUSPEND_FLAG];

	// Checks
	sequence clr_write_s;
		wr_stb && !halt_i && (adr_i == usb_buf_pkg::BUF_CSR_OFS) &&
			dat_i[0] && (block_release_i == 2'h0);
	endsequence
	sequence block_end_s;
		ep2_done_i && !halt_i && managed && !ep2_short_i &&
			(s_q.pkt_cnt == usb_buf_pkg::LAST_PKT);
	endsequence
	// Block end with the other block still owned by the coprocessor
	sequence block_busy_s;
		block_end_s ##0 (block_release_i == 2'h0) && !wr_stb &&
			!blk_avail(s_q.mode, s_q.blk_flags[~s_q.cur_blk]);
	endsequence
	sequence resume_seen_s;
		halt_i && s_q.act_sync[1] && s_q.ev_en[usb_buf_pkg::EV_END_OF_SUSPEND_FLAG]
			##1 halt_i;
	endsequence

	flow_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		clr_write_s |=> (s_q.blk_flags == 2'h0) && (s_q.pkt_cnt == 3'h0))
		else $error("clear did not reset flow state");
	normal_nak_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ep2_done_i && !halt_i && !managed |=>
		s_q.ep2_valid[$past(ep2_dir_in_i)] == 1'b0)
		else $error("normal mode did not return to nak");
	short_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ep2_done_i && !halt_i && managed && ep2_short_i && !ep2_dir_in_i
		|=> s_q.mode == usb_buf_pkg::MODE_NORMAL)
		else $error("short packet kept managed mode");
	addr_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ep2_done_i && !halt_i && managed && !ep2_short_i &&
		(s_q.pkt_cnt != usb_buf_pkg::LAST_PKT) && !wr_stb |=>
		ep2_addr_o == $past(ep2_addr_o) + 10'h040)
		else $error("ep2 address did not advance 64 bytes");
	block_switch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		block_end_s |=> (s_q.cur_blk != $past(s_q.cur_blk)) &&
		(s_q.pkt_cnt == 3'h0))
		else $error("block did not switch after 512 bytes");
	stall_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
		managed && !s_q.stalled &&
		!blk_avail(s_q.mode, s_q.blk_flags[s_q.cur_blk]) |->
		(ep2_rx_status_o == usb_buf_pkg::EP_NAK) &&
		(ep2_tx_status_o == usb_buf_pkg::EP_NAK))
		else $error("unavailable block not answered with nak");
	stall_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
		block_busy_s |=> (ep2_rx_status_o == usb_buf_pkg::EP_INVALID) ||
		(ep2_tx_status_o == usb_buf_pkg::EP_INVALID))
		else $error("endpoint not invalid without a free block");
	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	grant_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$onehot0(grant_o))
		else $error("more than one buffer owner");
	cpu_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!halt_i && (grant_o == 3'h0) && cpu_req_i |=> grant_o.cpu)
		else $error("cpu not granted first");
	halt_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
		halt_i |=> $stable(s_q.mode) && $stable(s_q.pkt_cnt) &&
		$stable(s_q.blk_flags))
		else $error("state changed in halt");
	irq_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!masks_open |-> !usb_irq_o && !end_of_suspend_flag_irq_o)
		else $error("interrupt issued while masked");
	// Master still holds address and direction while ack stands
	csr_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && !we_i && (adr_i == usb_buf_pkg::BUF_CSR_OFS) |->
		(dat_o[31:4] == 28'h0) && !dat_o[usb_buf_pkg::CSR_CLEAR_BIT])
		else $error("reserved or clear bit read as one");
	halt_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
		resume_seen_s |-> wake_halt_o)
		else $error("resume activity did not wake from halt");
endmodule // usb_endpoint_buffer_manager

//--- src/usb_buf_pkg.sv
// Package: constants and types of the endpoint buffer manager
package usb_buf_pkg;
	// Endpoint buffer sizes in bytes (two buffers each)
	localparam int EP0_BUF_BYTES = 16;
	localparam int EP1_BUF_BYTES = 16;
	localparam int EP2_BUF_BYTES = 64;
	localparam int BLOCK_BYTES   = 512;
	localparam int PKTS_PER_BLK  = BLOCK_BYTES / EP2_BUF_BYTES;
	localparam logic [2:0] LAST_PKT = 3'(PKTS_PER_BLK - 1);

	// Register byte offsets
	localparam logic [3:0] BUF_CSR_OFS = 4'h0;
	localparam logic [3:0] USB_CTL_OFS = 4'h4;
	localparam logic [3:0] EV_FLAG_OFS = 4'h8;
	localparam logic [3:0] EV_EN_OFS   = 4'hC;

	// Field positions
	localparam int CSR_CLEAR_BIT = 0;
	localparam int CSR_FLAGS_LSB = 1;
	localparam int CSR_INDEX_BIT = 3;
	localparam int CTL_MODE_LSB  = 0;
	localparam int CTL_VALID_LSB = 2;

	// Transfer mode encodings
	localparam logic [1:0] MODE_NORMAL   = 2'h0;
	localparam logic [1:0] MODE_UPLOAD   = 2'h1;
	localparam logic [1:0] MODE_DOWNLOAD = 2'h2;

	// Event bit positions
	localparam int EV_FRAME = 0;
	localparam int EV_RESET = 1;
	localparam int EV_END_OF_SUSPEND_FLAG = 2;
	localparam int EV_SUSPEND_REQUEST_FLAG  = 3;
	localparam int EV_ERROR = 4;
	localparam int EV_SETUP_OVERRUN_FLAG  = 5;
	localparam int EV_CTR   = 6;
	localparam int NUM_EV   = 7;

	// Reset values
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam logic [6:0] EV_RESET_VAL = 7'h00;

	typedef enum logic [1:0] {EP_INVALID, EP_NAK, EP_VALID} ep_status_e;

	// Arbiter grant, one-hot: cpu, usb, coprocessor
	typedef struct packed {
		logic cpu;
		logic usb;
		logic cop;
	} grant_s;

	typedef struct packed {
		logic [1:0]        mode;
		logic [1:0]        ep2_valid;
		logic              cur_blk;
		logic [2:0]        pkt_cnt;
		logic [1:0]        blk_flags;
		logic              buf_index;
		logic              stalled;
		logic [NUM_EV-1:0] ev_flags;
		logic [NUM_EV-1:0] ev_en;
		grant_s            grant;
		logic              ack;
		logic [7:0]        rdata;
		logic [1:0]        act_sync;
	} state_s;
endpackage

//--- tb/usb_far_side_model.sv
// Far-side model: serial engine strobes and coprocessor releases
`timescale 1ns/1ps
module usb_far_side_model (
	// Clock
	input  wire logic       clk_i,
	// Serial engine side
	output logic            done_o,
	output logic            dir_in_o,
	output logic            short_o,
	output logic [6:0]      event_o,
	output logic            activity_o,
	// Coprocessor side
	output logic [1:0]      release_o
);
	initial begin
		done_o = 1'b0;
		dir_in_o = 1'b0;
		short_o = 1'b0;
		event_o = 7'h00;
		activity_o = 1'b0;
		release_o = 2'h0;
	end
	// Qualifiers turn over once done drops, so stale values never pass
	task automatic pkt(input logic dir_in, input logic short_pkt);
		@(posedge clk_i);
		done_o <= 1'b1;
		dir_in_o <= dir_in;
		short_o <= short_pkt;
		@(posedge clk_i);
		done_o <= 1'b0;
		dir_in_o <= ~dir_in;
		short_o <= ~short_pkt;
		#1;
	endtask
	task automatic ev(input int b);
		@(posedge clk_i);
		event_o <= 7'h01 << b;
		@(posedge clk_i);
		event_o <= 7'h00;
		#1;
	endtask
	// One-cycle release strobe for block b
	task automatic rel(input int b);
		@(posedge clk_i);
		release_o <= 2'h1 << b;
		@(posedge clk_i);
		release_o <= 2'h0;
		#1;
	endtask
	// Held long enough to cross the pin synchroniser
	task automatic act();
		@(posedge clk_i);
		activity_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		activity_o <= 1'b0;
		#1;
	endtask
endmodule // usb_far_side_model

//--- tb/usb_endpoint_buffer_manager_bench.sv
// Bench: register, endpoint 2 flow, event and arbiter tests
`timescale 1ns/1ps
module usb_endpoint_buffer_manager_bench;
	logic clk_i, rst_i, cyc, stb, we, ack, idx, cpu_r, usb_r, cop_r;
	logic wait_s, halt_s, done, dir_in, shrt, act, usb_irq, es_irq, ww, wh;
	logic [3:0] adr;
	logic [31:0] wdat, dat, rd;
	logic [6:0] ev;
	logic [9:0] addr;
	logic [1:0] rel, mode, flags, gmask;
	usb_buf_pkg::ep_status_e rx_st, tx_st;
	usb_buf_pkg::grant_s grant;
	int error_cnt, num_checks, i;

	usb_endpoint_buffer_manager i_usb_endpoint_buffer_manager (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat), .ack_o(ack),
		.ep2_done_i(done), .ep2_dir_in_i(dir_in), .ep2_short_i(shrt),
		.usb_event_i(ev), .bus_activity_i(act), .ep2_rx_status_o(rx_st),
		.ep2_tx_status_o(tx_st), .ep2_addr_o(addr),
		.transfer_mode_field_o(mode), .block_release_i(rel),
		.block_status_flags_o(flags), .current_buffer_index_o(idx),
		.cpu_req_i(cpu_r), .usb_req_i(usb_r), .cop_req_i(cop_r),
		.grant_o(grant), .wait_i(wait_s), .halt_i(halt_s),
		.global_interrupt_masks_i(gmask), .usb_irq_o(usb_irq),
		.end_of_suspend_flag_irq_o(es_irq), .wake_wait_o(ww), .wake_halt_o(wh));
	usb_far_side_model i_usb_far_side_model (.clk_i(clk_i), .done_o(done),
		.dir_in_o(dir_in), .short_o(shrt), .event_o(ev),
		.activity_o(act), .release_o(rel));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s %0h/%0h", $time, m, got, exp);
		end
	endtask
	task automatic chk_st(input usb_buf_pkg::ep_status_e got, exp,
		input string m);
		chk(32'(got), 32'(exp), m);
	endtask
	// Classic cycle: request held until ack is sampled at an edge
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat;
		{cyc, stb} <= 2'h0;
		#1;
		if (n >= 20) begin
			error_cnt++;
			$display("wrong value at %0t: no ack", $time);
			test_done();
		end
	endtask

	initial begin
		error_cnt = 0;
		num_checks = 0;
		{rst_i, cyc, stb, we, adr, wdat} = {1'b1, 39'h0};
		{cpu_r, usb_r, cop_r, wait_s, halt_s, gmask} = 7'h00;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, usb_buf_pkg::BUF_CSR_OFS, 8'h00, rd);
		chk(rd, 0, "csr reset");
		wb(0, 4'h2, 8'h00, rd);
		chk(rd, 0, "unmapped");
		chk_st(rx_st, usb_buf_pkg::EP_NAK, "rx reset");
		$display("reset test done");
		wb(1, usb_buf_pkg::USB_CTL_OFS, 8'h04, rd);
		chk_st(rx_st, usb_buf_pkg::EP_VALID, "rx armed");
		i_usb_far_side_model.pkt(1'b0, 1'b0);
		chk_st(rx_st, usb_buf_pkg::EP_NAK, "rx done");
		wb(1, usb_buf_pkg::USB_CTL_OFS, 8'h08, rd);
		i_usb_far_side_model.pkt(1'b1, 1'b0);
		chk_st(tx_st, usb_buf_pkg::EP_NAK, "tx done");
		$display("normal mode test done");
		wb(1, usb_buf_pkg::USB_CTL_OFS, 8'h02, rd);
		chk(32'(mode), 32'(usb_buf_pkg::MODE_DOWNLOAD), "mode");
		for (i = 0; i < 16; i++) begin
			chk(32'(addr), i * 64, "ep2 address");
			chk_st(rx_st, usb_buf_pkg::EP_VALID, "rx free");
			i_usb_far_side_model.pkt(1'b0, 1'b0);
		end
		chk(32'(flags), 3, "both full");
		chk_st(rx_st, usb_buf_pkg::EP_INVALID, "no block");
		wb(0, usb_buf_pkg::BUF_CSR_OFS, 8'h00, rd);
		chk(rd & 32'h6, 32'h6, "csr flags");
		wb(1, usb_buf_pkg::BUF_CSR_OFS, 8'hFE, rd);
		wb(0, usb_buf_pkg::BUF_CSR_OFS, 8'h00, rd);
		chk(rd, 32'h6, "write zero");
		i_usb_far_side_model.rel(0);
		chk(32'(flags), 2, "released");
		chk_st(rx_st, usb_buf_pkg::EP_VALID, "resume");
		wb(1, usb_buf_pkg::BUF_CSR_OFS, 8'hFF, rd);
		wb(0, usb_buf_pkg::BUF_CSR_OFS, 8'h00, rd);
		chk(rd, 0, "clear");
		chk(32'(addr), 0, "counter clear");
		for (i = 0; i < 8; i++) i_usb_far_side_model.pkt(1'b0, 1'b0);
		i_usb_far_side_model.pkt(1'b0, 1'b1);
		chk(32'(mode), 32'(usb_buf_pkg::MODE_NORMAL), "short");
		wb(0, usb_buf_pkg::BUF_CSR_OFS, 8'h00, rd);
		chk(rd & 32'h8, 32'h8, "index");
		chk(32'(idx), 1, "index pin");
		$display("download test done");
		wb(1, usb_buf_pkg::BUF_CSR_OFS, 8'h01, rd);
		wb(1, usb_buf_pkg::USB_CTL_OFS, 8'h01, rd);
		chk_st(tx_st, usb_buf_pkg::EP_NAK, "not full");
		i_usb_far_side_model.rel(0);
		chk_st(tx_st, usb_buf_pkg::EP_VALID, "full");
		for (i = 0; i < 8; i++) i_usb_far_side_model.pkt(1'b1, 1'b0);
		chk(32'(flags), 0, "sent");
		chk_st(tx_st, usb_buf_pkg::EP_INVALID, "upload stall");
		$display("upload test done");
		wb(1, usb_buf_pkg::EV_EN_OFS, 8'h7F, rd);
		for (i = 0; i < 7; i++) begin
			i_usb_far_side_model.ev(i);
			wb(0, usb_buf_pkg::EV_FLAG_OFS, 8'h00, rd);
			chk(rd, 1 << i, "event flag");
			chk(32'(usb_irq), 32'(i != usb_buf_pkg::EV_END_OF_SUSPEND_FLAG),
				"usb irq");
			chk(32'(es_irq), 32'(i == usb_buf_pkg::EV_END_OF_SUSPEND_FLAG),
				"end_of_suspend_flag irq");
			wb(1, usb_buf_pkg::EV_FLAG_OFS, 8'h7F, rd);
		end
		@(posedge clk_i);
		gmask <= 2'h3;
		wait_s <= 1'b1;
		i_usb_far_side_model.ev(usb_buf_pkg::EV_CTR);
		chk(32'(usb_irq), 0, "masked");
		chk(32'(ww), 1, "wake wait");
		@(posedge clk_i);
		{wait_s, halt_s} <= 2'h1;
		i_usb_far_side_model.pkt(1'b1, 1'b0);
		chk(32'(addr), 32'h200, "frozen");
		i_usb_far_side_model.act();
		chk(32'(wh), 1, "wake halt");
		@(posedge clk_i);
		halt_s <= 1'b0;
		$display("event test done");
		@(posedge clk_i);
		{cpu_r, usb_r, cop_r} <= 3'h7;
		repeat (2) @(posedge clk_i);
		#1 chk(32'(grant), 4, "cpu first");
		@(posedge clk_i);
		cpu_r <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk(32'(grant), 2, "usb next");
		@(posedge clk_i);
		usb_r <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk(32'(grant), 1, "cop last");
		@(posedge clk_i);
		cpu_r <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1 chk(32'(grant), 1, "owner kept");
		$display("arbiter test done");
		test_done();
	end
endmodule // usb_endpoint_buffer_manager_bench
